// >>> hdl/sac_pkg.sv
// package of constants and types for the serial attenuator control block
package sac_pkg;
  localparam int FRAME_BITS = 16;
  localparam int BYTE_BITS = 8;
  localparam logic [7:0] ADDR_CHAN_ONE = 8'h00;
  localparam logic [7:0] ADDR_CHAN_TWO = 8'h01;
  localparam logic [7:0] CODE_FINE_LAST = 8'h5F;
  localparam logic [7:0] CODE_COARSE_FIRST = 8'h60;
  localparam logic [7:0] CODE_COARSE_LAST = 8'h7E;
  localparam logic [7:0] CODE_MUTE_FIRST = 8'h7F;
  localparam logic [7:0] RESET_LEVEL = 8'h7F;
  localparam logic RESET_MUTE = 1'b1;
  localparam int TAP_BITS = 7;
  localparam logic [6:0] RESET_TAP = 7'h00;
  localparam int SETUP_NS = 150;
  localparam int CLK_PERIOD_NS = 20;
  localparam int SETUP_CYCLES = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic [2:0] {
    SAC_IDLE = 3'b001,
    SAC_SHIFT = 3'b010,
    SAC_LATCH = 3'b100
  } sac_state_t;
endpackage

// >>> hdl/sac_sync.sv
// two flip-flop synchroniser for the link clock and data pins
`timescale 1ns/10ps
module sac_sync (
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // asynchronous level in, synchronised level out
  input wire logic async_i,
  output logic sync_o
);
  logic meta_ff;
  logic sync_ff;
  logic nxt_meta;
  logic nxt_sync;

  always_comb begin
    nxt_meta = async_i;
    nxt_sync = meta_ff;
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign sync_o = sync_ff;
endmodule

// >>> hdl/sac_decode.sv
// channel setting register: decodes a latched code into tap and mute
`timescale 1ns/10ps
module sac_decode
  import sac_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // load strobe and code
  input wire logic load_i,
  input wire logic [7:0] code_i,
  // setting
  output logic [7:0] level_o,
  output logic [6:0] tap_o,
  output logic mute_o,
  output logic coarse_o
);
  logic [7:0] level_ff;
  logic [6:0] tap_ff;
  logic mute_ff;
  logic coarse_ff;
  logic [7:0] nxt_level;
  logic [6:0] nxt_tap;
  logic nxt_mute;
  logic nxt_coarse;

  always_comb begin
    nxt_level = level_ff;
    nxt_tap = tap_ff;
    nxt_mute = mute_ff;
    nxt_coarse = coarse_ff;
    if (load_i) begin
      nxt_level = code_i;
      if (code_i >= CODE_MUTE_FIRST) begin
        // mute regardless of previous tap; see RULE_07, see RULE_09
        nxt_mute = 1'b1;
        nxt_coarse = 1'b0;
        nxt_tap = RESET_TAP;
      end else if (code_i >= CODE_COARSE_FIRST) begin
        // 1 dB steps 48..78 dB; see RULE_06
        nxt_mute = 1'b0;
        nxt_coarse = 1'b1;
        nxt_tap = code_i[6:0];
      end else begin
        // 0.5 dB steps 0..47.5 dB; see RULE_05
        nxt_mute = 1'b0;
        nxt_coarse = 1'b0;
        nxt_tap = code_i[6:0];
      end
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      // power-up mute; see RULE_08
      level_ff <= RESET_LEVEL;
      tap_ff <= RESET_TAP;
      mute_ff <= RESET_MUTE;
      coarse_ff <= 1'b0;
    end else begin
      level_ff <= nxt_level;
      tap_ff <= nxt_tap;
      mute_ff <= nxt_mute;
      coarse_ff <= nxt_coarse;
    end
  end

  assign level_o = level_ff;
  assign tap_o = tap_ff;
  assign mute_o = mute_ff;
  assign coarse_o = coarse_ff;

  AST_MUTE_CODE: assert property (@(posedge mclk_i) disable iff (reset_i) // see RULE_07
    load_i && code_i >= CODE_MUTE_FIRST |=> mute_ff && tap_ff == RESET_TAP)
    else $error("mute code did not mute channel");
  AST_FINE_CODE: assert property (@(posedge mclk_i) disable iff (reset_i) // see RULE_05
    load_i && code_i <= CODE_FINE_LAST |=> !mute_ff && !coarse_ff && level_ff == $past(code_i))
    else $error("fine code not decoded");
  AST_COARSE_CODE: assert property (@(posedge mclk_i) disable iff (reset_i) // see RULE_06
    load_i && code_i >= CODE_COARSE_FIRST && code_i <= CODE_COARSE_LAST |=> !mute_ff && coarse_ff)
    else $error("coarse code not decoded");
endmodule

// >>> hdl/sac_top.sv
// serial attenuator control: shift register, latch and two channel settings
// Summary of operation
// RULE_01: host drops enable 150 ns before first clock
// RULE_02: frame is address byte then level byte
// RULE_03: host sends MSB first, address first
// RULE_04: only addresses 00 and 01 change channels
// RULE_05: codes 00..5F give 0.5 dB steps
// RULE_06: codes 60..7E give 1 dB steps
// RULE_07: codes 7F and above mute the channel
// RULE_08: both channels muted after power-up
// RULE_09: mute code mutes from any setting
// RULE_10: old contents shift out while new shift in
// RULE_11: enable rising edge latches then decodes frame
// RULE_12: unaddressed channel keeps its setting
// RULE_13: chain of n needs 16n bits
// RULE_14: chain loads like single device via chain output
// RULE_15: each chained device decodes its own frame
// RULE_16: data captured on link clock rising edge
// RULE_17: clock edges ignored while enable high
// RULE_18: chain output is last stage, 16 clock delay
// RULE_19: unknown address leaves both channels unchanged
`timescale 1ns/10ps
module sac_top
  import sac_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // serial link pins
  input wire logic link_clk_i,
  input wire logic load_shift_n_i,
  input wire logic data_i,
  output logic data_o,
  // channel one setting
  output logic [7:0] ch1_level_o,
  output logic [6:0] ch1_tap_o,
  output logic ch1_mute_o,
  output logic ch1_coarse_o,
  // channel two setting
  output logic [7:0] ch2_level_o,
  output logic [6:0] ch2_tap_o,
  output logic ch2_mute_o,
  output logic ch2_coarse_o
);
  import sac_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic sclk_s;
  logic din_s;

  sac_sync u_sync_clk (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .async_i(link_clk_i),
    .sync_o(sclk_s)
  );
  sac_sync u_sync_din (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .async_i(data_i),
    .sync_o(din_s)
  );

  // enable pin synchroniser: resets to the pin's idle high level so that
  // leaving reset never looks like the end of a frame
  logic en_meta_ff;
  logic en_pin_ff;
  logic nxt_en_meta;
  logic nxt_en_pin;

  always_comb begin
    nxt_en_meta = load_shift_n_i;
    nxt_en_pin = en_meta_ff;
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      en_meta_ff <= 1'b1;
      en_pin_ff <= 1'b1;
    end else begin
      en_meta_ff <= nxt_en_meta;
      en_pin_ff <= nxt_en_pin;
    end
  end

  // shifting is allowed while the synchronised enable pin is low
  logic shift_en;
  assign shift_en = ~en_pin_ff;

  ////////////////////////////////////////////////////////////////////////
  // edge detection, shift register, chain output and frame latch
  logic sclk_prev_ff;
  logic shift_en_prev_ff;
  logic [15:0] shreg_ff;
  logic dout_ff;
  logic [7:0] addr_ff;
  logic [7:0] code_ff;
  sac_state_t state_ff;
  logic nxt_sclk_prev;
  logic nxt_shift_en_prev;
  logic [15:0] nxt_shreg;
  logic nxt_dout;
  logic [7:0] nxt_addr;
  logic [7:0] nxt_code;
  sac_state_t nxt_state;
  logic sclk_rise;
  logic latch_edge;

  assign sclk_rise = sclk_s & ~sclk_prev_ff;
  // rising edge of the active-low enable pin
  assign latch_edge = shift_en_prev_ff & ~shift_en;

  always_comb begin
    nxt_sclk_prev = sclk_s;
    nxt_shift_en_prev = shift_en;
    nxt_shreg = shreg_ff;
    nxt_dout = dout_ff;
    nxt_addr = addr_ff;
    nxt_code = code_ff;
    nxt_state = state_ff;
    case (state_ff)
      SAC_IDLE: begin
        if (shift_en) begin
          nxt_state = SAC_SHIFT;
        end
      end
      SAC_SHIFT: begin
        if (latch_edge) begin
          // see RULE_11, see RULE_02: capture frame, decode next cycle
          nxt_addr = shreg_ff[15:8];
          nxt_code = shreg_ff[7:0];
          nxt_state = SAC_LATCH;
        end else if (shift_en && sclk_rise) begin
          // see RULE_16, see RULE_17, see RULE_03: msb-first entry at bit 0
          nxt_shreg = {shreg_ff[14:0], din_s};
          // see RULE_10, see RULE_18, see RULE_14: last stage goes out
          nxt_dout = shreg_ff[15];
        end
      end
      SAC_LATCH: begin
        nxt_state = shift_en ? SAC_SHIFT : SAC_IDLE;
      end
      default: begin
        nxt_state = SAC_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      sclk_prev_ff <= 1'b0;
      shift_en_prev_ff <= 1'b0;
      shreg_ff <= 16'h0000;
      dout_ff <= 1'b0;
      addr_ff <= 8'hFF;
      code_ff <= RESET_LEVEL;
      state_ff <= SAC_IDLE;
    end else begin
      sclk_prev_ff <= nxt_sclk_prev;
      shift_en_prev_ff <= nxt_shift_en_prev;
      shreg_ff <= nxt_shreg;
      dout_ff <= nxt_dout;
      addr_ff <= nxt_addr;
      code_ff <= nxt_code;
      state_ff <= nxt_state;
    end
  end

  assign data_o = dout_ff;

  ////////////////////////////////////////////////////////////////////////
  // channel address decode and per-channel settings
  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] ch);
    addr_hit = (a == ch);
  endfunction

  logic decode_now;
  logic [1:0] load_ch;
  logic [7:0] lvl [2];
  logic [6:0] tap [2];
  logic mute [2];
  logic coarse [2];
  localparam logic [7:0] CH_ADDR [2] = '{ADDR_CHAN_ONE, ADDR_CHAN_TWO};

  assign decode_now = (state_ff == SAC_LATCH);

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_chan
      // see RULE_04, see RULE_12, see RULE_15, see RULE_19
      assign load_ch[gi] = decode_now & addr_hit(addr_ff, CH_ADDR[gi]);
      sac_decode u_dec (
        .mclk_i(mclk_i),
        .reset_i(reset_i),
        .load_i(load_ch[gi]),
        .code_i(code_ff),
        .level_o(lvl[gi]),
        .tap_o(tap[gi]),
        .mute_o(mute[gi]),
        .coarse_o(coarse[gi])
      );
    end
  endgenerate

  assign ch1_level_o = lvl[0];
  assign ch1_tap_o = tap[0];
  assign ch1_mute_o = mute[0];
  assign ch1_coarse_o = coarse[0];
  assign ch2_level_o = lvl[1];
  assign ch2_tap_o = tap[1];
  assign ch2_mute_o = mute[1];
  assign ch2_coarse_o = coarse[1];

  ////////////////////////////////////////////////////////////////////////
  // reference delay line for the chain output: an independent record of the
  // last 17 captured bits, so a wrong tap or an extra stage shows up
  logic [16:0] chain_ref_ff;
  logic [16:0] nxt_chain_ref;
  logic capture;

  assign capture = (state_ff == SAC_SHIFT) & shift_en & sclk_rise;

  always_comb begin
    nxt_chain_ref = chain_ref_ff;
    if (capture) begin
      nxt_chain_ref = {chain_ref_ff[15:0], din_s};
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      chain_ref_ff <= 17'h00000;
    end else begin
      chain_ref_ff <= nxt_chain_ref;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  // frame control, shifting, chain output stage and address decode
  AST_SHIFT_ONLY_LOW: assert property (@(posedge mclk_i) disable iff (reset_i) // see RULE_17
    !shift_en |=> $stable(shreg_ff))
    else $error("shift register moved while enable high");
  AST_SHIFT_IN: assert property (@(posedge mclk_i) disable iff (reset_i) // see RULE_16
    state_ff == SAC_SHIFT && shift_en && sclk_rise && !latch_edge |=> shreg_ff[0] == $past(din_s))
    else $error("serial bit not captured");
  AST_CHAIN_OUT: assert property (@(posedge mclk_i) disable iff (reset_i) // see RULE_18
    state_ff == SAC_SHIFT && shift_en && sclk_rise && !latch_edge |=> dout_ff == $past(shreg_ff[15]))
    else $error("chain output not last stage");
  AST_LATCH_FRAME: assert property (@(posedge mclk_i) disable iff (reset_i) // see RULE_11
    state_ff == SAC_SHIFT && latch_edge |=> addr_ff == $past(shreg_ff[15:8]) && code_ff == $past(shreg_ff[7:0])
    ##1 state_ff != SAC_LATCH)
    else $error("frame not latched on enable rise");
  AST_KEEP_OTHER: assert property (@(posedge mclk_i) disable iff (reset_i) // see RULE_12
    decode_now && addr_ff != ADDR_CHAN_TWO |=> $stable(ch2_level_o) && $stable(ch2_mute_o))
    else $error("unaddressed channel changed");
  AST_BAD_ADDR: assert property (@(posedge mclk_i) disable iff (reset_i) // see RULE_19
    decode_now && addr_ff != ADDR_CHAN_ONE && addr_ff != ADDR_CHAN_TWO |=> $stable(ch1_level_o) && $stable(ch2_level_o))
    else $error("unknown address changed a channel");
  AST_CH1_LOAD: assert property (@(posedge mclk_i) disable iff (reset_i) // see RULE_04
    decode_now && addr_ff == ADDR_CHAN_ONE |=> ch1_level_o == $past(code_ff))
    else $error("channel one not loaded");
  AST_STATE_ONEHOT: assert property (@(posedge mclk_i) disable iff (reset_i) // see RULE_11
    $onehot(state_ff))
    else $error("frame state not one-hot");
  AST_LATCH_SINGLE: assert property (@(posedge mclk_i) disable iff (reset_i) // see RULE_11
    state_ff == SAC_LATCH |=> state_ff != SAC_LATCH)
    else $error("latch state lasted more than one cycle");
  AST_DECODE_AFTER_EDGE: assert property (@(posedge mclk_i) disable iff (reset_i) // see RULE_11
    decode_now |-> $past(latch_edge))
    else $error("decode without an enable rise");
  // chain output
  AST_CHAIN_HOLD: assert property (@(posedge mclk_i) disable iff (reset_i) // see RULE_10
    !(shift_en && sclk_rise) |=> $stable(dout_ff))
    else $error("chain output moved without a capture");
  AST_CHAIN_DELAY: assert property (@(posedge mclk_i) disable iff (reset_i) // see RULE_18
    capture |=> dout_ff == chain_ref_ff[16] && shreg_ff == chain_ref_ff[15:0])
    else $error("chain output not delayed by a full frame");
  // channel settings
  AST_ONE_CHANNEL: assert property (@(posedge mclk_i) disable iff (reset_i) // see RULE_15
    $onehot0(load_ch))
    else $error("more than one channel loaded");
  AST_CH2_LOAD: assert property (@(posedge mclk_i) disable iff (reset_i) // see RULE_04
    decode_now && addr_ff == ADDR_CHAN_TWO |=> ch2_level_o == $past(code_ff))
    else $error("channel two not loaded");
  AST_KEEP_CH1: assert property (@(posedge mclk_i) disable iff (reset_i) // see RULE_12
    decode_now && addr_ff != ADDR_CHAN_ONE |=> $stable(ch1_level_o) && $stable(ch1_mute_o))
    else $error("unaddressed channel one changed");
  AST_HOLD_SETTING: assert property (@(posedge mclk_i) disable iff (reset_i) // see RULE_12
    !decode_now |=> $stable(ch1_level_o) && $stable(ch2_level_o) && $stable(ch1_mute_o) && $stable(ch2_mute_o))
    else $error("channel setting changed without a frame");
  AST_CH1_MUTE: assert property (@(posedge mclk_i) disable iff (reset_i) // see RULE_09
    decode_now && addr_ff == ADDR_CHAN_ONE && code_ff >= CODE_MUTE_FIRST |=> ch1_mute_o && ch1_tap_o == RESET_TAP)
    else $error("channel one not muted");
  AST_CH2_MUTE: assert property (@(posedge mclk_i) disable iff (reset_i) // see RULE_09
    decode_now && addr_ff == ADDR_CHAN_TWO && code_ff >= CODE_MUTE_FIRST |=> ch2_mute_o && ch2_tap_o == RESET_TAP)
    else $error("channel two not muted");
  AST_CH1_TAP: assert property (@(posedge mclk_i) disable iff (reset_i) // see RULE_05
    decode_now && addr_ff == ADDR_CHAN_ONE && code_ff < CODE_MUTE_FIRST |=> !ch1_mute_o && {1'b0, ch1_tap_o} == $past(code_ff))
    else $error("channel one tap wrong");
  AST_CH2_TAP: assert property (@(posedge mclk_i) disable iff (reset_i) // see RULE_05
    decode_now && addr_ff == ADDR_CHAN_TWO && code_ff < CODE_MUTE_FIRST |=> !ch2_mute_o && {1'b0, ch2_tap_o} == $past(code_ff))
    else $error("channel two tap wrong");
  AST_CH1_COARSE: assert property (@(posedge mclk_i) disable iff (reset_i) // see RULE_06
    decode_now && addr_ff == ADDR_CHAN_ONE && code_ff >= CODE_COARSE_FIRST && code_ff <= CODE_COARSE_LAST
    |=> ch1_coarse_o && !ch1_mute_o)
    else $error("channel one coarse region wrong");
  AST_CH2_COARSE: assert property (@(posedge mclk_i) disable iff (reset_i) // see RULE_06
    decode_now && addr_ff == ADDR_CHAN_TWO && code_ff >= CODE_COARSE_FIRST && code_ff <= CODE_COARSE_LAST
    |=> ch2_coarse_o && !ch2_mute_o)
    else $error("channel two coarse region wrong");
endmodule

// >>> bench/sac_host.sv
// host model driving the three serial link pins
`timescale 1ns/10ps
module sac_host (
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // link pins
  output logic link_clk_o,
  output logic load_shift_n_o,
  output logic data_o,
  // chain output expectation
  output logic smp_o,
  output logic exp_o
);
  bit hist[$];
  initial begin
    link_clk_o = 1'b0;
    load_shift_n_o = 1'b1;
    data_o = 1'b0;
    smp_o = 1'b0;
    exp_o = 1'b0;
  end
  always @(posedge reset_i) begin
    hist.delete();
  end
  task automatic hold(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  // expected chain bit is the one shifted in 16 edges earlier
  task automatic expect_out();
    exp_o = (hist.size() > 16) ? hist[hist.size() - 17] : 1'b0;
    smp_o = ~smp_o;
  endtask
  // with en clear the clock pulses come while the enable stays high
  task automatic send(input logic [31:0] bits, input int n, input bit en);
    load_shift_n_o = ~en;
    hold(8);
    for (int i = n - 1; i >= 0; i--) begin
      data_o = bits[i];
      hold(4);
      if (i != n - 1) expect_out();
      link_clk_o = 1'b1;
      if (en) hist.push_back(bits[i]);
      hold(4);
      link_clk_o = 1'b0;
    end
    hold(4);
    expect_out();
    load_shift_n_o = 1'b1;
    data_o = ~data_o;
    hold(8);
  endtask
endmodule

// >>> bench/serial_attenuator_control_tb.sv
// self-checking bench for the serial attenuator control block
`timescale 1ns/10ps
module serial_attenuator_control_tb;
  import sac_pkg::*;
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  logic link_clk, load_n, din, dout, smp, exp_bit;
  logic [7:0] l1, l2;
  logic [6:0] t1, t2;
  logic m1, m2, c1, c2;
  logic [7:0] lvl [2];
  logic [7:0] codes [8] = '{8'h00, 8'h7F, 8'h5F, 8'hFF, 8'h60, 8'h80, 8'h7E, 8'h7F};
  int miscompares = 0;
  int compares = 0;
  always #10 mclk_i = ~mclk_i;
  sac_host host (.mclk_i(mclk_i), .reset_i(reset_i), .link_clk_o(link_clk), .load_shift_n_o(load_n),
    .data_o(din), .smp_o(smp), .exp_o(exp_bit));
  sac_top dut (.mclk_i(mclk_i), .reset_i(reset_i), .link_clk_i(link_clk), .load_shift_n_i(load_n),
    .data_i(din), .data_o(dout), .ch1_level_o(l1), .ch1_tap_o(t1), .ch1_mute_o(m1), .ch1_coarse_o(c1),
    .ch2_level_o(l2), .ch2_tap_o(t2), .ch2_mute_o(m2), .ch2_coarse_o(c2));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // f selects tap, mute or coarse
  function automatic logic [7:0] expect_of(input logic [7:0] v, input int f);
    case (f)
      0: return (v >= CODE_MUTE_FIRST) ? 8'h00 : {1'b0, v[6:0]};
      1: return {7'h00, v >= CODE_MUTE_FIRST};
      default: return {7'h00, v >= CODE_COARSE_FIRST && v <= CODE_COARSE_LAST};
    endcase
  endfunction
  always @(smp) if (!reset_i) check({7'h00, dout}, {7'h00, exp_bit});
  task automatic chk_all();
    check(l1, lvl[0]);
    check(l2, lvl[1]);
    check({1'b0, t1}, expect_of(lvl[0], 0));
    check({1'b0, t2}, expect_of(lvl[1], 0));
    check({7'h00, m1}, expect_of(lvl[0], 1));
    check({7'h00, m2}, expect_of(lvl[1], 1));
    check({7'h00, c1}, expect_of(lvl[0], 2));
    check({7'h00, c2}, expect_of(lvl[1], 2));
  endtask
  // only the last 16 bits shifted decide the latched frame
  task automatic frame(input logic [15:0] lead, input logic [7:0] a, input logic [7:0] d, input int n);
    host.send({lead, a, d}, n, 1'b1);
    if (a == ADDR_CHAN_ONE) lvl[0] = d;
    if (a == ADDR_CHAN_TWO) lvl[1] = d;
    chk_all();
  endtask
  task automatic do_reset();
    reset_i = 1'b1;
    host.hold(20);
    reset_i = 1'b0;
    lvl[0] = RESET_LEVEL;
    lvl[1] = RESET_LEVEL;
    host.hold(4);
    chk_all();
  endtask
  initial begin
    repeat (60000) @(posedge mclk_i);
    miscompares++;
    end_sim();
  end
  initial begin
    void'($urandom(24595));
    do_reset();
    for (int k = 0; k < 8; k++) begin
      frame(16'h0000, ADDR_CHAN_ONE, codes[k], 16);
      frame(16'h0000, ADDR_CHAN_TWO, codes[(k + 3) % 8], 16);
    end
    for (int k = 0; k < 6; k++) begin
      frame(16'h0000, 8'($urandom_range(2, 255)), 8'($urandom), 16);
      host.send(32'($urandom), 16, 1'b0);
      chk_all();
      frame(16'($urandom), 8'($urandom_range(0, 1)), 8'($urandom), 32);
    end
    for (int k = 0; k < 20; k++) begin
      frame(16'h0000, 8'($urandom_range(0, 3)), 8'($urandom), 16);
    end
    do_reset();
    frame(16'h0000, ADDR_CHAN_TWO, 8'h30, 16);
    end_sim();
  end
endmodule
